/* inc/icc_pkg.sv */
/*
 * input capture channel group: shared constants, register map, field
 * positions and capture mode codes.
 * assumes a single 100 MHz clock and a 32-bit APB register bus.
 */
package icc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ICC_NCH   = 8;     // number of capture channels
    localparam int ICC_DEPTH = 4;     // capture words per channel buffer
    localparam int ICC_TW    = 16;    // time base / capture word width
    localparam int ICC_AW    = 8;     // apb address width
    localparam int ICC_CW    = 3;     // channel index width
    localparam int ICC_NW    = 3;     // buffer occupancy width

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ICC_AW-1:0] ICC_CH_SPACE_END = 8'h40; // channels below this
    localparam logic [ICC_AW-1:0] ICC_IF_ADDR      = 8'h40; // interrupt flags, w1c
    localparam logic [ICC_AW-1:0] ICC_IE_ADDR      = 8'h44; // interrupt enables
    localparam int               ICC_CH_LSB       = 3;     // channel index in address
    localparam int               ICC_SLOT_BIT     = 2;     // 0 = control, 1 = buffer

    // ------------------------------------------------------------
    // capture_control_reg fields
    // ------------------------------------------------------------
    localparam int ICC_SIDL_BIT  = 13;  // stop_in_idle
    localparam int ICC_TBSEL_BIT = 7;   // timebase_select: 1 = timer_a, 0 = timer_b
    localparam int ICC_IEC_LSB   = 5;   // interrupt_event_count, two bits
    localparam int ICC_OV_BIT    = 4;   // capture_overflow_flag, read only
    localparam int ICC_BNE_BIT   = 3;   // buffer_not_empty_flag, read only
    localparam int ICC_MODE_LSB  = 0;   // capture_mode_select, three bits

    localparam logic [ICC_TW-1:0] ICC_CON_RST = 16'h0000;

    // ------------------------------------------------------------
    // capture modes and prescaler end counts
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ICC_OFF       = 3'b000,
        ICC_EDGE_BOTH = 3'b001,
        ICC_FALL      = 3'b010,
        ICC_RISE      = 3'b011,
        ICC_RISE4     = 3'b100,
        ICC_RISE16    = 3'b101,
        ICC_RSVD      = 3'b110,
        ICC_IRQ_ONLY  = 3'b111
    } icc_mode_e;

    localparam logic [3:0] ICC_PS4_LAST  = 4'h3;
    localparam logic [3:0] ICC_PS16_LAST = 4'hf;

endpackage

/* rtl/icc_pin_edge.sv */
/*
 * pin synchroniser and edge detector for one capture input.
 * assumes the pin is asynchronous to i_clock; pulses last one cycle.
 */
module icc_pin_edge (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // pin
    input  wire logic i_pin,
    // edge pulses
    output logic      o_rise,
    output logic      o_fall
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // two flops then a history flop for edge detection
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_rise = sync_r & ~prev_r;
    assign o_fall = ~sync_r & prev_r;

endmodule // icc_pin_edge

/* rtl/icc_top.sv */
/*
 * input capture channel group with an APB register slave.
 * each channel watches a pin, stores the selected time base count in a
 * four word buffer and raises a per-channel interrupt flag.
 * assumes timer counts and cpu sleep/idle levels come from i_clock logic;
 * capture pins are asynchronous.
 */
module icc_top
    import icc_pkg::*;
(
    // clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_rst,
    // apb slave
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [ICC_AW-1:0]    i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    // capture pins and time bases
    input  wire logic [ICC_NCH-1:0]   i_capture_pin,
    input  wire logic [ICC_TW-1:0]    i_timer_a,
    input  wire logic [ICC_TW-1:0]    i_timer_b,
    // cpu power state
    input  wire logic                 i_cpu_sleep,
    input  wire logic                 i_cpu_idle,
    // interrupt and wake
    output logic      [ICC_NCH-1:0]   o_capture_irq,
    output logic                      o_wake
);

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------

    // address falls in the per-channel window
    function automatic logic is_chan(input logic [ICC_AW-1:0] a);
        return (a < ICC_CH_SPACE_END);
    endfunction

    // channel number carried by an address
    function automatic logic [ICC_CW-1:0] chan_of(input logic [ICC_AW-1:0] a);
        return a[ICC_CH_LSB +: ICC_CW];
    endfunction

    // address names the buffer word of a channel
    function automatic logic is_buf(input logic [ICC_AW-1:0] a);
        return is_chan(a) && a[ICC_SLOT_BIT] && (a[1:0] == 2'b00);
    endfunction

    // address names the control word of a channel
    function automatic logic is_con(input logic [ICC_AW-1:0] a);
        return is_chan(a) && !a[ICC_SLOT_BIT] && (a[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [ICC_TW-1:0]  fifo_r   [ICC_NCH][ICC_DEPTH];
    logic [ICC_NW-1:0]  count_r  [ICC_NCH];
    logic [3:0]         presc_r  [ICC_NCH];
    logic [1:0]         evcnt_r  [ICC_NCH];
    icc_mode_e          mode_r   [ICC_NCH];
    logic [1:0]         iec_r    [ICC_NCH];
    logic [ICC_NCH-1:0] tbsel_r;
    logic [ICC_NCH-1:0] sidl_r;
    logic [ICC_NCH-1:0] ovf_r;
    logic [ICC_NCH-1:0] flag_r;
    logic [ICC_NCH-1:0] ie_r;
    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;
    logic [ICC_NCH-1:0] irq_r;
    logic               wake_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire logic              setup_ph   = i_psel & ~i_penable;
    wire logic              access_ok  = i_psel & i_penable & pready_r;
    wire logic              wr_ok      = access_ok & i_pwrite;
    wire logic              rd_ok      = access_ok & ~i_pwrite;
    wire logic [ICC_CW-1:0] acc_ch     = chan_of(i_paddr);
    wire logic              hit_con    = is_con(i_paddr);
    wire logic              hit_buf    = is_buf(i_paddr);
    wire logic              hit_if     = (i_paddr == ICC_IF_ADDR);
    wire logic              hit_ie     = (i_paddr == ICC_IE_ADDR);
    wire logic              mapped     = hit_con | hit_buf | hit_if | hit_ie;

    // per-channel views shared with the bus read mux
    logic [ICC_TW-1:0]  con_word [ICC_NCH];
    logic [ICC_TW-1:0]  head_word[ICC_NCH];
    logic [ICC_NCH-1:0] flag_nxt;
    logic [ICC_NCH-1:0] wake_hit;

    // read data for the address held in the setup phase
    wire logic [31:0] rd_word =
        hit_con ? {16'h0000, con_word[acc_ch]}  :
        hit_buf ? {16'h0000, head_word[acc_ch]} :
        hit_if  ? {24'h000000, flag_r}          :
        hit_ie  ? {24'h000000, ie_r}            : 32'h00000000;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    // one copy per channel
    for (genvar g = 0; g < ICC_NCH; g++) begin : g_ch
        logic rise;
        logic fall;

        icc_pin_edge u_edge (
            .i_clock (i_clock),
            .i_rst   (i_rst),
            .i_pin   (i_capture_pin[g]),
            .o_rise  (rise),
            .o_fall  (fall)
        );

        wire logic m_off  = (mode_r[g] == ICC_OFF);
        wire logic m_both = (mode_r[g] == ICC_EDGE_BOTH);
        wire logic m_fall = (mode_r[g] == ICC_FALL);
        wire logic m_rise = (mode_r[g] == ICC_RISE);
        wire logic m_r4   = (mode_r[g] == ICC_RISE4);
        wire logic m_r16  = (mode_r[g] == ICC_RISE16);
        wire logic m_irq  = (mode_r[g] == ICC_IRQ_ONLY);

        // stop-in-idle halts, otherwise idle runs fully
        wire logic run    = ~i_cpu_sleep & ~(i_cpu_idle & sidl_r[g]);
        wire logic ps_hit = rise & ((m_r4 & (presc_r[g] == ICC_PS4_LAST)) |
                                    (m_r16 & (presc_r[g] == ICC_PS16_LAST)));
        // no capture events while the cpu sleeps
        wire logic event_q = run & ((m_both & (rise | fall)) | (m_fall & fall) |
                                    (m_rise & rise) | ps_hit);
        wire logic pop     = rd_ok & hit_buf & (acc_ch == ICC_CW'(g)) &
                             (count_r[g] != '0);
        wire logic full    = (count_r[g] == ICC_NW'(ICC_DEPTH)) & ~pop;
        wire logic store   = event_q & ~ovf_r[g] & ~full;
        // fifth event on a full buffer, not in mode 001
        wire logic ovf_set = event_q & full & ~m_both;
        // interrupt every (count + 1) stored captures
        wire logic ev_hit  = store & (evcnt_r[g] == iec_r[g]);
        wire logic [ICC_TW-1:0] tb = tbsel_r[g] ? i_timer_a : i_timer_b;
        wire logic [ICC_NW-1:0] widx = count_r[g] - ICC_NW'(pop);

        // every edge flags in mode 001 while run is high, count ignored
        wire logic set_both = m_both & run & (rise | fall);
        // mode 111 only interrupts, in any power state
        wire logic set_irq  = m_irq & rise;
        wire logic set_cnt  = ev_hit & ~m_both;
        wire logic clr_sw   = wr_ok & hit_if & i_pwdata[g];

        // set wins over a software clear in the same cycle
        assign flag_nxt[g] = set_both | set_irq | set_cnt | (flag_r[g] & ~clr_sw);
        // wake from sleep or idle on mode 111 with enable
        assign wake_hit[g] = set_irq & ie_r[g] & (i_cpu_sleep | i_cpu_idle);

        // not-empty flag follows the buffer occupancy
        assign con_word[g] = {2'b00, sidl_r[g], 5'b00000, tbsel_r[g], iec_r[g],
                              ovf_r[g], (count_r[g] != '0), mode_r[g]};
        // an empty buffer shows whatever word is left at the head
        assign head_word[g] = fifo_r[g][0];

        // control register writes
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                mode_r[g]  <= icc_mode_e'(ICC_CON_RST[ICC_MODE_LSB +: 3]);
                iec_r[g]   <= ICC_CON_RST[ICC_IEC_LSB +: 2];
                tbsel_r[g] <= ICC_CON_RST[ICC_TBSEL_BIT];
                sidl_r[g]  <= ICC_CON_RST[ICC_SIDL_BIT];
            end else if (wr_ok && hit_con && acc_ch == ICC_CW'(g)) begin
                mode_r[g]  <= icc_mode_e'(i_pwdata[ICC_MODE_LSB +: 3]);
                iec_r[g]   <= i_pwdata[ICC_IEC_LSB +: 2];
                tbsel_r[g] <= i_pwdata[ICC_TBSEL_BIT];
                sidl_r[g]  <= i_pwdata[ICC_SIDL_BIT];
            end
        end

        // edge prescaler and interrupt event counter
        always_ff @(posedge i_clock) begin
            // cleared by reset and by the off mode
            if (i_rst || m_off) begin
                presc_r[g] <= 4'h0;
            end else if (rise && run && (m_r4 || m_r16)) begin
                presc_r[g] <= ps_hit ? 4'h0 : presc_r[g] + 4'h1;
            end
            if (i_rst || m_off) begin
                evcnt_r[g] <= 2'b00;
            end else if (store) begin
                evcnt_r[g] <= ev_hit ? 2'b00 : evcnt_r[g] + 2'b01;
            end
        end

        // buffer occupancy and overflow lock
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                count_r[g] <= '0;
                ovf_r[g]   <= 1'b0;
            end else begin
                count_r[g] <= count_r[g] + ICC_NW'(store) - ICC_NW'(pop);
                // lock releases once the buffer is drained
                if (ovf_set) begin
                    ovf_r[g] <= 1'b1;
                end else if (pop && count_r[g] == ICC_NW'(1)) begin
                    ovf_r[g] <= 1'b0;
                end
            end
        end

        // four word buffer, read shifts words forward
        always_ff @(posedge i_clock) begin
            if (pop) begin
                for (int k = 0; k < ICC_DEPTH - 1; k++) begin
                    fifo_r[g][k] <= fifo_r[g][k+1];
                end
            end
            // store time base at the first free slot
            if (store) begin
                fifo_r[g][widx[1:0]] <= tb;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt flags and enables
    // ------------------------------------------------------------

    // flags and enables, enables steer the irq and wake outputs
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            flag_r <= '0;
            ie_r   <= '0;
        end else begin
            flag_r <= flag_nxt;
            if (wr_ok && hit_ie) begin
                ie_r <= i_pwdata[ICC_NCH-1:0];
            end
        end
    end

    // registered interrupt and wake outputs
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            irq_r  <= '0;
            wake_r <= 1'b0;
        end else begin
            // enable gates the flag onto the line
            irq_r  <= flag_r & ie_r;
            wake_r <= |wake_hit;
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------

    // one wait-free access cycle; data latched in the setup cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~mapped;
            if (setup_ph) begin
                prdata_r <= i_pwrite ? 32'h00000000 : rd_word;
            end
        end
    end

    assign o_prdata      = prdata_r;
    assign o_pready      = pready_r;
    assign o_pslverr     = pslverr_r;
    assign o_capture_irq = irq_r;
    assign o_wake        = wake_r;

endmodule // icc_top

/* test/icc_far_model.sv */
/* far side: two free running time bases and the capture pin drivers.
   assumes one clock and a synchronous active high reset. */
module icc_far_model
    import icc_pkg::*;
(
    // clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    // pin levels asked for by the bench
    input  wire logic [ICC_NCH-1:0] i_pin_req,
    // to the block
    output logic      [ICC_NCH-1:0] o_pin,
    output logic      [ICC_TW-1:0]  o_timer_a,
    output logic      [ICC_TW-1:0]  o_timer_b,
    output logic                    o_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] div_r;

    // tick marks the cycle right after a time base step
    assign o_tick = (div_r == 4'h0);

    // timers always run
    // time bases step once per 16 clocks, pins follow the request
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            div_r     <= 4'h0;
            o_timer_a <= 16'h0100;
            o_timer_b <= 16'hb000;
            o_pin     <= '0;
        end else begin
            div_r <= div_r + 4'h1;
            o_pin <= i_pin_req;
            if (div_r == 4'hf) begin
                o_timer_a <= o_timer_a + 16'h1;
                o_timer_b <= o_timer_b + 16'h1;
            end
        end
    end
endmodule // icc_far_model

/* test/icc_top_props.sv */
/* checker: apb answer timing, error answers, irq gating, wake pulse.
   sees only ports of icc_top; bound below. */
module icc_top_props
    import icc_pkg::*;
(
    // clock and reset
    input wire logic               i_clock,
    input wire logic               i_rst,
    // apb
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic               i_pwrite,
    input wire logic [ICC_AW-1:0]  i_paddr,
    input wire logic [31:0]        i_pwdata,
    input wire logic [31:0]        o_prdata,
    input wire logic               o_pready,
    input wire logic               o_pslverr,
    // power state and outputs
    input wire logic               i_cpu_sleep,
    input wire logic               i_cpu_idle,
    input wire logic [ICC_NCH-1:0] o_capture_irq,
    input wire logic               o_wake
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    logic [ICC_NCH-1:0] ie_r;
    logic               bad;

    // unmapped or misaligned address
    assign bad = (i_paddr > ICC_IE_ADDR) || (i_paddr[1:0] != 2'b00);

    // shadow of the enable register
    always_ff @(posedge i_clock) begin
        if (i_rst)
            ie_r <= '0;
        else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == ICC_IE_ADDR)
            ie_r <= i_pwdata[ICC_NCH-1:0];
    end

    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_answer;
        i_psel && i_penable && o_pready;
    endsequence

    a_ready_after_setup: assert property (s_setup |=> s_answer)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (s_answer |=> !o_pready)
        else $error("ready longer than one cycle");
    a_ready_has_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("ready without setup");
    a_err_bad_addr: assert property ((s_setup ##0 bad) |=> o_pslverr)
        else $error("no error for unmapped address");
    a_err_good_addr: assert property ((s_setup ##0 !bad) |=> !o_pslverr)
        else $error("error for mapped address");
    a_err_zero_data: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("refused read data not zero");
    a_irq_gated: assert property ((o_capture_irq & ~$past(ie_r)) == '0)
        else $error("irq without enable");
    a_wake_pulse: assert property (o_wake |=> !o_wake)
        else $error("wake longer than one cycle");
    a_wake_cause: assert property (o_wake |-> $past((i_cpu_sleep || i_cpu_idle) && ie_r != '0))
        else $error("wake while awake or disabled");
endmodule // icc_top_props

bind icc_top icc_top_props i_icc_top_props (
    .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cpu_sleep(i_cpu_sleep),
    .i_cpu_idle(i_cpu_idle), .o_capture_irq(o_capture_irq), .o_wake(o_wake)
);

/* test/icc_top_tb.sv */
/* testbench: apb master, reference capture buffer, mode rows, corner cases.
   assumes icc_far_model drives pins and time bases, checker is bound. */
module icc_top_tb
    import icc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0]  ch;
        logic [15:0] con;
        logic [4:0]  n;
    } icc_row_s;
    localparam icc_row_s ROWS [5] = '{'{3'd0, 16'h0002, 5'd3}, '{3'd1, 16'h0083, 5'd2},
        '{3'd2, 16'h0004, 5'd8}, '{3'd7, 16'h0085, 5'd16}, '{3'd4, 16'h0001, 5'd2}};
    localparam logic [7:0] BAD [2] = '{8'h48, 8'h06};
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic sleep = 1'b0, idle = 1'b0, ovf = 1'b0, cap_en = 1'b1, pready, pslverr, wake, ftick, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [ICC_NCH-1:0] pin_req = '0, pin, irq;
    logic [15:0] tmr_a, tmr_b, con_w, q [$];
    int miscompares = 0, checked = 0, nrise = 0, wakes = 0;

    always #5 clock = ~clock;
    icc_far_model i_icc_far_model (.i_clock(clock), .i_rst(rst), .i_pin_req(pin_req),
        .o_pin(pin), .o_timer_a(tmr_a), .o_timer_b(tmr_b), .o_tick(ftick));
    icc_top i_icc_top (.i_clock(clock), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_capture_pin(pin), .i_timer_a(tmr_a),
        .i_timer_b(tmr_b), .i_cpu_sleep(sleep), .i_cpu_idle(idle), .o_capture_irq(irq),
        .o_wake(wake));

    // counts wake pulses
    always @(posedge clock) if (wake === 1'b1) wakes++;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // waits for the answer; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
        chk({31'h0, er}, 32'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, e);
        chk({31'h0, er}, 32'h0);
    endtask
    task automatic set_mode(input logic [2:0] ch, input logic [15:0] c);
        con_w = c;
        nrise = 0;
        wr({2'b00, ch, 3'b000}, {16'h0, c});
    endtask
    task automatic tick();
        do begin
            @(posedge clock);
        end while (ftick !== 1'b1);
    endtask
    // reference buffer: keeps the selected time base on a capture
    task automatic hit();
        logic [15:0] t;
        t = con_w[ICC_TBSEL_BIT] ? tmr_a : tmr_b;
        if (!cap_en || (con_w[2:0] == ICC_EDGE_BOTH && q.size() == ICC_DEPTH)) return;
        if (ovf || q.size() == ICC_DEPTH) ovf = 1'b1;
        else q.push_back(t);
    endtask
    task automatic pulses(input logic [2:0] ch, input int n);
        repeat (n) begin
            tick();
            pin_req[ch] <= 1'b1;
            nrise++;
            case (con_w[2:0])
                ICC_RISE, ICC_EDGE_BOTH: hit();
                ICC_RISE4: if (nrise % 4 == 0) hit();
                ICC_RISE16: if (nrise % 16 == 0) hit();
                default: ;
            endcase
            tick();
            pin_req[ch] <= 1'b0;
            if (con_w[2:0] == ICC_FALL || con_w[2:0] == ICC_EDGE_BOTH) hit();
        end
    endtask
    task automatic drain(input logic [2:0] ch);
        logic [15:0] c;
        tick();
        c = con_w | (16'(ovf) << ICC_OV_BIT) | (16'(q.size() != 0) << ICC_BNE_BIT);
        rdc({2'b00, ch, 3'b000}, {16'h0, c});
        // never read past the last entry
        while (q.size() > 0) rdc({2'b00, ch, 3'b100}, {16'h0, q.pop_front()});
        ovf = 1'b0;
        rdc({2'b00, ch, 3'b000}, {16'h0, con_w});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rdc(8'h00, 32'h0);
        rdc(8'h38, 32'h0);
        wr(8'h00, 32'h18);
        rdc(8'h00, 32'h0);
        foreach (BAD[i]) begin
            apb(1'b0, BAD[i], 32'h0, rd, er);
            chk({31'h0, er}, 32'h1);
            chk(rd, 32'h0);
        end
        wr(ICC_IE_ADDR, 32'hff);
        rdc(ICC_IE_ADDR, 32'hff);
        foreach (ROWS[i]) begin
            set_mode(ROWS[i].ch, ROWS[i].con);
            pulses(ROWS[i].ch, int'(ROWS[i].n));
            drain(ROWS[i].ch);
            rdc(ICC_IF_ADDR, 32'h1 << ROWS[i].ch);
            chk({24'h0, irq}, 32'h1 << ROWS[i].ch);
            wr(ICC_IF_ADDR, 32'hff);
            rdc(ICC_IF_ADDR, 32'h0);
            set_mode(ROWS[i].ch, 16'h0);
        end
        set_mode(3'd0, 16'h0003);
        pulses(3'd0, 6);
        drain(3'd0);
        pulses(3'd0, 1);
        drain(3'd0);
        wr(ICC_IF_ADDR, 32'hff);
        set_mode(3'd1, 16'h0061);
        pulses(3'd1, 1);
        rdc(ICC_IF_ADDR, 32'h2);
        pulses(3'd1, 2);
        drain(3'd1);
        set_mode(3'd2, 16'h0023);
        pulses(3'd2, 1);
        rdc(ICC_IF_ADDR, 32'h2);
        pulses(3'd2, 1);
        rdc(ICC_IF_ADDR, 32'h6);
        drain(3'd2);
        set_mode(3'd3, 16'h0004);
        pulses(3'd3, 2);
        set_mode(3'd3, 16'h0000);
        set_mode(3'd3, 16'h0004);
        pulses(3'd3, 4);
        drain(3'd3);
        // interrupt only mode used in sleep, in idle and while awake
        set_mode(3'd5, 16'h0007);
        sleep <= 1'b1;
        pulses(3'd5, 1);
        chk(wakes, 32'd1);
        sleep <= 1'b0;
        idle <= 1'b1;
        pulses(3'd5, 1);
        chk(wakes, 32'd2);
        idle <= 1'b0;
        pulses(3'd5, 1);
        chk(wakes, 32'd2);
        drain(3'd5);
        set_mode(3'd6, 16'h0003);
        idle <= 1'b1;
        pulses(3'd6, 1);
        set_mode(3'd6, 16'h2003);
        cap_en = 1'b0;
        pulses(3'd6, 1);
        idle <= 1'b0;
        sleep <= 1'b1;
        pulses(3'd6, 1);
        sleep <= 1'b0;
        drain(3'd6);
        // flags left standing: ch1, ch2, ch3, ch5, ch6
        rdc(ICC_IF_ADDR, 32'h6e);
        chk({24'h0, irq}, 32'h6e);
        wr(ICC_IE_ADDR, 32'h0);
        @(posedge clock);
        chk({24'h0, irq}, 32'h0);
        end_of_test();
    end
endmodule // icc_top_tb
